// >>> psc_core.sv
// Priority threshold and thread stack privilege control registers
`timescale 1ns/10ps
// Summary of operation
// RULE_01: Nonzero threshold blocks priorities at or above it
// RULE_02: Threshold in bits 7:0, zero disables
// RULE_03: Unimplemented low threshold bits read zero
// RULE_04: Control bit 2 shows FP context active
// RULE_05: FP context bit decides FP state save
// RULE_06: Control bit 1 selects main or process stack
// RULE_07: Handler mode: stack select reads zero, writes ignored
// RULE_08: Handler mode always uses main stack
// RULE_09: Entry and return update control from return code
// RULE_10: Control bit 0 makes Thread unprivileged
// RULE_11: After reset Thread uses main stack
// RULE_12: Writing stack select 1 in Thread picks process
// RULE_13: After barrier new stack pointer is used
// RULE_14: Every exception but reset enters Handler mode
// RULE_15: Byte, halfword, word, FP32, FP64 operands supported
// RULE_16: Data accesses are little-endian
// RULE_17: Exception number zero means Thread mode
// RULE_18: Both registers reset to zero
module psc_core
    import psc_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Special register move port
    input wire logic i_sr_wr,
    input wire logic [1:0] i_sr_sel,
    input wire logic [31:0] i_sr_wdata,
    input wire logic [1:0] i_sr_rsel,
    output logic [31:0] o_sr_rdata,
    // Barrier
    input wire logic i_sync_barrier,
    // Exception sequencing
    input wire logic [8:0] i_exc_number,
    input wire logic i_exc_entry,
    input wire logic i_exception_return_code,
    input wire logic [31:0] i_exception_return_code_code,
    input wire logic i_fp_used,
    // Candidate exception
    input wire logic [7:0] i_cand_prio,
    input wire logic i_cand_valid,
    output logic o_cand_allowed,
    output logic o_save_fp_state,
    // Mode and stack status
    output logic o_handler_mode,
    output logic o_use_process_stack,
    output logic o_privileged,
    // Data operand steering
    input wire logic [31:0] i_dat_wdata,
    input wire logic [2:0] i_dat_size,
    input wire logic [1:0] i_dat_addr_lo,
    output logic [31:0] o_dat_lane,
    output logic [3:0] o_dat_be,
    output logic o_dat_size_ok
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] thresh_ff;
    logic [7:0] nxt_thresh;
    logic [2:0] ctrl_ff;
    logic [2:0] nxt_ctrl;
    logic proc_stack_ff;
    logic nxt_proc_stack;
    psc_mode_t mode_ff;
    psc_mode_t nxt_mode;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] lane_ff;
    logic [31:0] nxt_lane;
    logic [3:0] be_ff;
    logic [3:0] nxt_be;
    logic size_ok_ff;
    logic nxt_size_ok;
    logic handler_now;
    logic [2:0] ctrl_view;

    psc_lane_if lif ();

    psc_lane u_lane (
        .lif (lif)
    );

    assign lif.wdata = i_dat_wdata;
    assign lif.size = i_dat_size;
    assign lif.addr_lo = i_dat_addr_lo;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign handler_now = (i_exc_number != 9'h000); // RULE_17

    // Stack select reads zero in Handler mode
    always_comb
    begin
        ctrl_view = ctrl_ff;
        if (handler_now)
        begin
            ctrl_view[PSC_CTRL_STKSEL] = 1'b0; // RULE_07
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_thresh = thresh_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mode = handler_now ? PSC_ST_HANDLER : PSC_ST_THREAD; // RULE_14
        if (i_sr_wr && (i_sr_sel == PSC_SEL_THRESH))
        begin
            nxt_thresh = i_sr_wdata[7:0] & PSC_PRIO_MASK; // RULE_03
        end
        if (i_sr_wr && (i_sr_sel == PSC_SEL_CTRL))
        begin
            nxt_ctrl[PSC_CTRL_UNPRIV] = i_sr_wdata[PSC_CTRL_UNPRIV]; // RULE_10
            nxt_ctrl[PSC_CTRL_FPACT] = i_sr_wdata[PSC_CTRL_FPACT];
            if (!handler_now)
            begin
                nxt_ctrl[PSC_CTRL_STKSEL] = i_sr_wdata[PSC_CTRL_STKSEL]; // RULE_12
            end
        end
        if (i_fp_used)
        begin
            nxt_ctrl[PSC_CTRL_FPACT] = 1'b1; // RULE_04
        end
        // Hardware sequencing wins over a software write in the same cycle
        if (i_exc_entry)
        begin
            nxt_ctrl[PSC_CTRL_FPACT] = 1'b0; // RULE_09
        end
        else if (i_exception_return_code)
        begin
            nxt_ctrl[PSC_CTRL_STKSEL] = i_exception_return_code_code[PSC_EXCRET_STKSEL]; // RULE_09
            nxt_ctrl[PSC_CTRL_FPACT] = ~i_exception_return_code_code[PSC_EXCRET_NOFP];
        end
    end

    // Stack in use changes only at the barrier or a mode change
    always_comb
    begin
        nxt_proc_stack = proc_stack_ff;
        if (i_exc_entry || handler_now)
        begin
            nxt_proc_stack = 1'b0; // RULE_08
        end
        else if (i_exception_return_code)
        begin
            nxt_proc_stack = i_exception_return_code_code[PSC_EXCRET_STKSEL] &
                             i_exception_return_code_code[PSC_EXCRET_THREAD];
        end
        else if (i_sync_barrier)
        begin
            nxt_proc_stack = ctrl_ff[PSC_CTRL_STKSEL]; // RULE_13
        end
    end

    // ------------------------------------------------------------
    // Read path and data lanes, registered
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_rdata = 32'h0;
        unique case (i_sr_rsel)
            PSC_SEL_THRESH: nxt_rdata = {24'h0, thresh_ff}; // RULE_02
            PSC_SEL_CTRL: nxt_rdata = {29'h0, ctrl_view}; // RULE_04
            default: nxt_rdata = 32'h0;
        endcase
        nxt_lane = lif.lane_data; // RULE_16
        nxt_be = lif.lane_be;
        nxt_size_ok = lif.size_ok; // RULE_15
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            thresh_ff <= PSC_THRESH_RST; // RULE_18
            ctrl_ff <= PSC_CTRL_RST; // RULE_11
            proc_stack_ff <= 1'b0;
            mode_ff <= PSC_ST_THREAD;
            rdata_ff <= 32'h0;
            lane_ff <= 32'h0;
            be_ff <= 4'h0;
            size_ok_ff <= 1'b0;
        end
        else
        begin
            thresh_ff <= nxt_thresh;
            ctrl_ff <= nxt_ctrl;
            proc_stack_ff <= nxt_proc_stack;
            mode_ff <= nxt_mode;
            rdata_ff <= nxt_rdata;
            lane_ff <= nxt_lane;
            be_ff <= nxt_be;
            size_ok_ff <= nxt_size_ok;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero threshold never masks; otherwise equal or lower urgency is refused
    assign o_cand_allowed = i_cand_valid &&
                            ((thresh_ff == PSC_THRESH_RST) ||
                             (i_cand_prio < thresh_ff)); // RULE_01
    assign o_save_fp_state = i_exc_entry & ctrl_ff[PSC_CTRL_FPACT]; // RULE_05
    assign o_handler_mode = (mode_ff == PSC_ST_HANDLER);
    assign o_use_process_stack = proc_stack_ff; // RULE_06
    assign o_privileged = o_handler_mode | ~ctrl_ff[PSC_CTRL_UNPRIV]; // RULE_10
    assign o_sr_rdata = rdata_ff;
    assign o_dat_lane = lane_ff;
    assign o_dat_be = be_ff;
    assign o_dat_size_ok = size_ok_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_sp_write;
        i_sr_wr && i_sr_sel == PSC_SEL_CTRL && !handler_now && !i_exc_entry && !i_exception_return_code;
    endsequence

    sequence s_barrier_thread;
        i_sync_barrier && !handler_now && !i_exc_entry && !i_exception_return_code;
    endsequence

    AST_MASK_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_01
        (i_cand_valid && thresh_ff != 8'h00 && i_cand_prio >= thresh_ff) |-> !o_cand_allowed)
        else $error("masked exception allowed");
    AST_ZERO_NOMASK: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_02
        (i_cand_valid && thresh_ff == 8'h00) |-> o_cand_allowed)
        else $error("zero threshold masked");
    AST_LOW_BITS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_03
        (i_sr_wr && i_sr_sel == PSC_SEL_THRESH) |=> (thresh_ff[3:0] == 4'h0 &&
            thresh_ff[7:4] == $past(i_sr_wdata[7:4])))
        else $error("threshold write wrong");
    AST_FP_SAVE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_05
        (i_exc_entry && $past(ctrl_ff[PSC_CTRL_FPACT]) && !$past(i_exc_entry) &&
            !$past(i_exception_return_code) && !$past(i_sr_wr)) |-> o_save_fp_state)
        else $error("fp save mismatch");
    AST_HDL_READ: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_07
        (handler_now && i_sr_rsel == PSC_SEL_CTRL) |=> !o_sr_rdata[PSC_CTRL_STKSEL])
        else $error("stack select visible in handler");
    AST_HDL_MAIN: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_08
        (handler_now && !i_exception_return_code) |=> !o_use_process_stack)
        else $error("handler on process stack");
    AST_RET_STACK_SELECT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_09
        (i_exception_return_code && !i_exc_entry) |=>
            ctrl_ff[PSC_CTRL_STKSEL] == $past(i_exception_return_code_code[PSC_EXCRET_STKSEL]))
        else $error("return code not applied");
    AST_SWITCH_PROC: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_12
        (s_sp_write and i_sr_wdata[PSC_CTRL_STKSEL]) ##1
            (s_barrier_thread and !(i_sr_wr && i_sr_sel == PSC_SEL_CTRL))
            |=> o_use_process_stack)
        else $error("process stack not selected");
    AST_BARRIER_STK: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_13
        s_barrier_thread |=> o_use_process_stack == $past(ctrl_ff[PSC_CTRL_STKSEL]))
        else $error("barrier did not apply stack");
    AST_RESET_CLR: assert property (@(posedge i_mclk) // RULE_18
        !i_rst_n |=> (thresh_ff == 8'h00 && ctrl_ff == 3'h0 && !o_use_process_stack))
        else $error("reset values wrong");

endmodule : psc_core

// >>> psc_lane.sv
// Little-endian byte lane placement for data operands
`timescale 1ns/10ps
module psc_lane
    import psc_pkg::*;
(
    psc_lane_if.lane lif
);

    // ------------------------------------------------------------
    // Lane steering; byte 0 at the lowest address
    // ------------------------------------------------------------
    always_comb
    begin
        lif.lane_data = 32'h0;
        lif.lane_be = 4'h0;
        lif.size_ok = 1'b1;
        unique case (lif.size)
            PSC_SZ_BYTE:
            begin
                lif.lane_data = {4{lif.wdata[7:0]}}; // RULE_16
                lif.lane_be = 4'h1 << lif.addr_lo; // RULE_16
            end
            PSC_SZ_HALF:
            begin
                lif.lane_data = {2{lif.wdata[15:0]}};
                lif.lane_be = lif.addr_lo[1] ? 4'hC : 4'h3; // RULE_16
                lif.size_ok = ~lif.addr_lo[0];
            end
            PSC_SZ_WORD, PSC_SZ_FP32, PSC_SZ_FP64:
            begin
                // Word, FP32 and FP64 all use the four lanes as one word and need a word address
                lif.lane_data = lif.wdata;
                lif.lane_be = 4'hF;
                lif.size_ok = (lif.addr_lo == 2'h0);
            end
            default:
            begin
                lif.size_ok = 1'b0; // RULE_15
            end
        endcase
    end

endmodule : psc_lane

// >>> psc_lane_if.sv
// Interface: byte lane steering between the control core and the lane unit
`timescale 1ns/10ps
interface psc_lane_if;
    import psc_pkg::*;
    logic [31:0] wdata;
    logic [2:0] size;
    logic [1:0] addr_lo;
    logic [31:0] lane_data;
    logic [3:0] lane_be;
    logic size_ok;
    modport ctl (output wdata, output size, output addr_lo,
                 input lane_data, input lane_be, input size_ok);
    modport lane (input wdata, input size, input addr_lo,
                  output lane_data, output lane_be, output size_ok);
endinterface : psc_lane_if

// >>> psc_pkg.sv
// Package: constants and types for the priority mask and stack control block
package psc_pkg;

    // ------------------------------------------------------------
    // Register selectors on the special register move port
    // ------------------------------------------------------------
    localparam logic [1:0] PSC_SEL_THRESH = 2'h1;
    localparam logic [1:0] PSC_SEL_CTRL = 2'h2;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int PSC_PRIO_W = 8;
    localparam int PSC_PRIO_IMPL = 4;
    localparam logic [7:0] PSC_PRIO_MASK = 8'hF0;
    localparam int PSC_CTRL_UNPRIV = 0;
    localparam int PSC_CTRL_STKSEL = 1;
    localparam int PSC_CTRL_FPACT = 2;
    localparam int PSC_EXCNUM_W = 9;
    localparam int PSC_EXCRET_STKSEL = 2;
    localparam int PSC_EXCRET_NOFP = 4;
    localparam int PSC_EXCRET_THREAD = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PSC_THRESH_RST = 8'h00;
    localparam logic [2:0] PSC_CTRL_RST = 3'h0;

    // ------------------------------------------------------------
    // Data operand sizes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PSC_SZ_BYTE = 3'h0,
        PSC_SZ_HALF = 3'h1,
        PSC_SZ_WORD = 3'h2,
        PSC_SZ_FP32 = 3'h3,
        PSC_SZ_FP64 = 3'h4
    } psc_size_t;

    // ------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSC_ST_THREAD = 2'h0,
        PSC_ST_HANDLER = 2'h1
    } psc_mode_t;

endpackage : psc_pkg

// >>> tb_priority_mask_and_stack_control.sv
// Self-checking testbench for the priority mask and stack control core
`timescale 1ns/10ps
module tb_priority_mask_and_stack_control
    import psc_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic i_mclk, i_rst_n, i_sr_wr, i_sync_barrier, i_exc_entry, i_exception_return_code, i_fp_used;
    logic i_cand_valid, o_cand_allowed, o_save_fp_state, o_handler_mode;
    logic o_use_process_stack, o_privileged, o_dat_size_ok;
    logic [1:0] i_sr_sel, i_sr_rsel, i_dat_addr_lo;
    logic [2:0] i_dat_size;
    logic [3:0] o_dat_be;
    logic [7:0] i_cand_prio;
    logic [8:0] i_exc_number;
    logic [31:0] i_sr_wdata, o_sr_rdata, i_exception_return_code_code, i_dat_wdata, o_dat_lane;
    logic [31:0] wd, rd, code;
    logic [36:0] ex;
    int n_errors = 0;
    int checks_done = 0;

    psc_core DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sr_wr(i_sr_wr),
        .i_sr_sel(i_sr_sel), .i_sr_wdata(i_sr_wdata), .i_sr_rsel(i_sr_rsel),
        .o_sr_rdata(o_sr_rdata), .i_sync_barrier(i_sync_barrier),
        .i_exc_number(i_exc_number),
        .i_exc_entry(i_exc_entry), .i_exception_return_code(i_exception_return_code),
        .i_exception_return_code_code(i_exception_return_code_code), .i_fp_used(i_fp_used),
        .i_cand_prio(i_cand_prio), .i_cand_valid(i_cand_valid),
        .o_cand_allowed(o_cand_allowed), .o_save_fp_state(o_save_fp_state),
        .o_handler_mode(o_handler_mode), .o_use_process_stack(o_use_process_stack),
        .o_privileged(o_privileged), .i_dat_wdata(i_dat_wdata), .i_dat_size(i_dat_size),
        .i_dat_addr_lo(i_dat_addr_lo), .o_dat_lane(o_dat_lane), .o_dat_be(o_dat_be),
        .o_dat_size_ok(o_dat_size_ok));

    always #12.5 i_mclk = ~i_mclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic conclude();
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Strobe held across one sampling edge, then one idle edge
    task automatic sr_write(input logic [1:0] sel, input logic [31:0] data);
        i_sr_wr = 1'b1;
        i_sr_sel = sel;
        i_sr_wdata = data;
        @(negedge i_mclk);
        i_sr_wr = 1'b0;
        @(negedge i_mclk);
    endtask : sr_write

    task automatic sr_read(input logic [1:0] sel, output logic [31:0] val);
        i_sr_rsel = sel;
        @(negedge i_mclk);
        val = o_sr_rdata;
    endtask : sr_read

    function automatic logic allowed_exp(input logic [7:0] thr, input logic [7:0] p);
        return (thr == 8'h00) || (p < thr);
    endfunction : allowed_exp

    // Packed as {size ok, byte enables, lane data}
    function automatic logic [36:0] lane_exp(input logic [2:0] sz, input logic [1:0] a,
                                             input logic [31:0] d);
        case (sz)
            PSC_SZ_BYTE: return {1'b1, 4'h1 << a, {4{d[7:0]}}};
            PSC_SZ_HALF: return {~a[0], a[1] ? 4'hC : 4'h3, {2{d[15:0]}}};
            3'h5, 3'h6, 3'h7: return 37'h0;
            default: return {a == 2'h0, 4'hF, d};
        endcase
    endfunction : lane_exp

    // ------------------------------------------------------------
    // Watchdog, far beyond the roughly 120 cycles the tests take
    // ------------------------------------------------------------
    initial
    begin
        #(25 * 5000);
        n_errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {i_mclk, i_rst_n, i_sr_wr, i_sync_barrier, i_exc_entry, i_exception_return_code, i_fp_used} = 7'h00;
        {i_sr_sel, i_sr_rsel, i_dat_addr_lo, i_dat_size, i_cand_valid} = 10'h000;
        {i_cand_prio, i_exc_number} = 17'h00000;
        {i_sr_wdata, i_exception_return_code_code, i_dat_wdata} = 96'h0;
        void'($urandom(22640));
        repeat (16) @(negedge i_mclk);
        i_rst_n = 1'b1;
        @(negedge i_mclk);
        sr_read(PSC_SEL_THRESH, rd);
        chk("thresh_rst", 32'h0, rd);
        sr_read(PSC_SEL_CTRL, rd);
        chk("ctrl_rst", 32'h0, rd);
        chk("priv_rst", 32'h1, {31'h0, o_privileged});
        chk("stk_rst", 32'h0, {31'h0, o_use_process_stack});
        // Threshold write, read back and masking; first pass is zero, second hits equality
        for (int k = 0; k < 24; k++)
        begin
            wd = (k == 0) ? 32'h0 : $urandom();
            sr_write(PSC_SEL_THRESH, wd);
            sr_read(PSC_SEL_THRESH, rd);
            chk("thresh_rd", {24'h0, wd[7:0] & PSC_PRIO_MASK}, rd);
            i_cand_prio = (k == 1) ? rd[7:0] : 8'($urandom());
            i_cand_valid = (k != 2);
            #1;
            chk("cand_allowed", {31'h0, (k != 2) && allowed_exp(rd[7:0], i_cand_prio)},
                {31'h0, o_cand_allowed});
        end
        // Thread mode: unprivileged, process stack only after the barrier
        i_sr_wr = 1'b1;
        i_sr_sel = PSC_SEL_CTRL;
        i_sr_wdata = 32'hABCD_00F3;
        @(negedge i_mclk);
        i_sr_wr = 1'b0;
        i_sync_barrier = 1'b1;
        chk("stk_pre_barrier", 32'h0, {31'h0, o_use_process_stack});
        @(negedge i_mclk);
        i_sync_barrier = 1'b0;
        chk("stk_barrier", 32'h1, {31'h0, o_use_process_stack});
        sr_read(PSC_SEL_CTRL, rd);
        chk("ctrl_thread", 32'h3, rd);
        chk("priv_thread", 32'h0, {31'h0, o_privileged});
        i_fp_used = 1'b1;
        @(negedge i_mclk);
        i_fp_used = 1'b0;
        sr_read(PSC_SEL_CTRL, rd);
        chk("ctrl_fp", 32'h7, rd);
        // Two entry and return round trips: process stack with FP, then main without
        for (int j = 0; j < 2; j++)
        begin
            code = j ? 32'hFFFF_FFF9 : 32'hFFFF_FFED;
            i_exc_number = j ? 9'h003 : 9'h00B;
            i_exc_entry = 1'b1;
            #1;
            chk("save_fp", 32'h1, {31'h0, o_save_fp_state});
            @(negedge i_mclk);
            i_exc_entry = 1'b0;
            chk("handler", 32'h1, {31'h0, o_handler_mode});
            chk("stk_handler", 32'h0, {31'h0, o_use_process_stack});
            chk("priv_handler", 32'h1, {31'h0, o_privileged});
            sr_write(PSC_SEL_CTRL, 32'h3);
            sr_read(PSC_SEL_CTRL, rd);
            chk("ctrl_handler", 32'h1, rd);
            i_exception_return_code_code = code;
            i_exc_number = 9'd0;
            i_exception_return_code = 1'b1;
            @(negedge i_mclk);
            i_exception_return_code = 1'b0;
            @(negedge i_mclk);
            chk("thread", 32'h0, {31'h0, o_handler_mode});
            chk("stk_ret", {31'h0, code[2]}, {31'h0, o_use_process_stack});
            sr_read(PSC_SEL_CTRL, rd);
            chk("ctrl_ret", {29'h0, ~code[4], code[2], 1'b1}, rd);
        end
        // Operand lanes: byte, halfword, misaligned halfword, word, both floats, bad size
        for (int j = 0; j < 7; j++)
        begin
            wd = $urandom();
            i_dat_wdata = wd;
            i_dat_size = (j < 3) ? ((j == 0) ? 3'h0 : 3'h1) : 3'(j - 1);
            i_dat_addr_lo = (j == 0) ? 2'($urandom()) : ((j == 1) ? 2'h2 : ((j == 2) ? 2'h3 : 2'h0));
            ex = lane_exp(i_dat_size, i_dat_addr_lo, wd);
            @(negedge i_mclk);
            chk("dat_ok", {31'h0, ex[36]}, {31'h0, o_dat_size_ok});
            if (ex[36])
            begin
                chk("dat_be", {28'h0, ex[35:32]}, {28'h0, o_dat_be});
                chk("dat_lane", ex[31:0], o_dat_lane);
            end
        end
        conclude();
    end
endmodule : tb_priority_mask_and_stack_control
